// ==== verilog/usb_host_command_status_regs.sv ====
// command, status and interrupt register group of the host controller
//
// Functional notes
// RULE1 - command register at 20h, writes act as commands
// RULE2 - command resets with bits 19,11,9,8 set
// RULE3 - bit 0 runs or stops the schedule
// RULE4 - bit 1 resets the whole controller
// RULE5 - bit 7 light reset keeps port state
// RULE6 - bit 7 reads zero when not implemented
// RULE7 - software writes reserved bits with reset values
// RULE8 - status register at 24h, write one clears
// RULE9 - status holds controller events, no transactions
// RULE10 - status bit 3 set on index wrap
// RULE11 - status bit 2 set on port change
// RULE12 - reserved read/write enable register at 28h
// RULE13 - index advances each microframe, width follows size
// RULE14 - zero writes keep flags; reset bit self-clears
//
// The implementer's own choice: the plain strobed port.
module usb_host_command_status_regs #(
  parameter int NUM_PORTS = 1,
  parameter int MICROFRAME_CYCLES = hc_regs_pkg::MICROFRAME_CYCLES,
  parameter int RESET_HOLD_CYCLES = hc_regs_pkg::RESET_HOLD_CYCLES,
  parameter bit LIGHT_RESET_EN = 1'b1
) (
  input wire logic mclk, // core clock, 40 MHz
  input wire logic rst_b, // async reset, active low
  input wire hc_regs_pkg::reg_req_t req, // register bus request
  output logic [31:0] rdata, // read data, cycle after read strobe
  input wire logic [NUM_PORTS-1:0] port_status_change, // per-port change
  input wire logic [NUM_PORTS-1:0] companion_owned, // port given away
  input wire logic [NUM_PORTS-1:0] force_resume_rise, // resume seen
  output logic schedule_run, // schedule execution enabled
  output logic controller_reset, // controller logic held in reset
  output logic port_logic_reset, // port state held in reset
  output logic [13:0] frame_index, // current frame index
  output logic irq // level interrupt
);

  localparam int CNT_W = $clog2(RESET_HOLD_CYCLES + 1);
  localparam int UF_W = $clog2(MICROFRAME_CYCLES + 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD =
    CNT_W'(RESET_HOLD_CYCLES - 1);
  localparam logic [UF_W-1:0] UF_LAST = UF_W'(MICROFRAME_CYCLES - 1);

  if (NUM_PORTS < 1 || NUM_PORTS > 15) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and 15");
  end
  if (MICROFRAME_CYCLES < 2) begin : g_bad_uframe
    $error("MICROFRAME_CYCLES must be at least 2");
  end
  if (RESET_HOLD_CYCLES < 1) begin : g_bad_hold
    $error("RESET_HOLD_CYCLES must be at least 1");
  end

  // highest index value before wrap, per selected frame list size
  function automatic logic [13:0] wrap_point(input logic [1:0] fls);
    logic [13:0] w;
    w = hc_regs_pkg::WRAP_1024;
    case (fls)
      hc_regs_pkg::FLS_512: w = hc_regs_pkg::WRAP_512;
      hc_regs_pkg::FLS_256: w = hc_regs_pkg::WRAP_256;
      default: w = hc_regs_pkg::WRAP_1024;
    endcase
    return w;
  endfunction : wrap_point

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : hit

  hc_regs_pkg::ctrl_state_t state_reg;
  hc_regs_pkg::ctrl_state_t state_next;
  logic [CNT_W-1:0] hold_cnt_reg;
  logic [31:0] cmd_reg;
  logic [31:0] status_reg;
  logic [31:0] intr_rsvd_reg;
  logic [31:0] mask_reg;
  logic [1:0] fls_reg;
  logic [13:0] frame_index_reg;
  logic [UF_W-1:0] uf_cnt_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic ctrl_rst_reg;
  logic port_rst_reg;

  logic idle;
  logic reset_done;
  logic wr_ok;
  logic cmd_write;
  logic start_full;
  logic start_light;
  logic uf_tick;
  logic [13:0] wrap;
  logic rollover_evt;
  logic port_evt;
  logic [31:0] status_set;
  logic [31:0] status_clr;
  logic [31:0] cmd_write_value;

  assign idle = state_reg == hc_regs_pkg::CTRL_IDLE;
  assign reset_done = !idle && hold_cnt_reg == '0;
  // writes during a reset sequence are dropped: the registers are being
  // forced back to their reset values and a late write would race that
  assign wr_ok = req.wr && idle;
  assign cmd_write = wr_ok && hit(req.addr, hc_regs_pkg::OFS_HOST_COMMAND);
  assign start_full =
    cmd_write && req.wdata[hc_regs_pkg::CMD_FULL_RESET_BIT]; // RULE4
  // full reset wins when software sets both reset bits at once
  assign start_light = cmd_write && LIGHT_RESET_EN && !start_full &&
    req.wdata[hc_regs_pkg::CMD_LIGHT_RESET_BIT]; // RULE5

  // value stored on a plain command write
  always_comb begin
    cmd_write_value = req.wdata; // RULE7
    if (!LIGHT_RESET_EN) begin
      cmd_write_value[hc_regs_pkg::CMD_LIGHT_RESET_BIT] = 1'b0; // RULE6
    end
  end

  // reset sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hc_regs_pkg::CTRL_IDLE: begin
        if (start_full) begin
          state_next = hc_regs_pkg::CTRL_FULL_RESET; // RULE4
        end else if (start_light) begin
          state_next = hc_regs_pkg::CTRL_LIGHT_RESET; // RULE5
        end
      end
      hc_regs_pkg::CTRL_FULL_RESET: begin
        if (reset_done) begin
          state_next = hc_regs_pkg::CTRL_IDLE;
        end
      end
      hc_regs_pkg::CTRL_LIGHT_RESET: begin
        if (reset_done) begin
          state_next = hc_regs_pkg::CTRL_IDLE;
        end
      end
      default: state_next = hc_regs_pkg::CTRL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= hc_regs_pkg::CTRL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_reg <= '0;
    end else if (start_full || start_light) begin
      hold_cnt_reg <= HOLD_LOAD;
    end else if (!idle && hold_cnt_reg != '0) begin
      hold_cnt_reg <= hold_cnt_reg - CNT_W'(1);
    end
  end

  // reset outputs follow the sequencer; ports only see the full reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_rst_reg <= 1'b0;
      port_rst_reg <= 1'b0;
    end else begin
      ctrl_rst_reg <= state_next != hc_regs_pkg::CTRL_IDLE; // RULE4
      port_rst_reg <=
        state_next == hc_regs_pkg::CTRL_FULL_RESET; // RULE5
    end
  end

  // host_command
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_reg <= hc_regs_pkg::CMD_RESET_VALUE; // RULE2
    end else if (reset_done) begin
      cmd_reg <= hc_regs_pkg::CMD_RESET_VALUE; // RULE14
    end else if (start_full) begin
      cmd_reg <= hc_regs_pkg::CMD_RESET_VALUE |
        (32'h1 << hc_regs_pkg::CMD_FULL_RESET_BIT); // RULE4
    end else if (start_light) begin
      cmd_reg <= hc_regs_pkg::CMD_RESET_VALUE |
        (32'h1 << hc_regs_pkg::CMD_LIGHT_RESET_BIT); // RULE5
    end else if (cmd_write) begin
      cmd_reg <= cmd_write_value; // RULE1
    end
  end

  // microframe timer runs only while the schedule is running
  assign uf_tick = idle && cmd_reg[hc_regs_pkg::CMD_RUN_STOP_BIT] &&
    uf_cnt_reg == UF_LAST; // RULE13

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      uf_cnt_reg <= '0;
    end else if (!idle || !cmd_reg[hc_regs_pkg::CMD_RUN_STOP_BIT]) begin
      uf_cnt_reg <= '0; // RULE3
    end else if (uf_cnt_reg == UF_LAST) begin
      uf_cnt_reg <= '0;
    end else begin
      uf_cnt_reg <= uf_cnt_reg + UF_W'(1); // RULE13
    end
  end

  assign wrap = wrap_point(fls_reg); // RULE13
  assign rollover_evt = uf_tick && (frame_index_reg & wrap) == wrap;

  // stopping keeps the index where it was, so a restart continues
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frame_index_reg <= '0;
    end else if (!idle) begin
      frame_index_reg <= '0;
    end else if (uf_tick) begin
      frame_index_reg <= (frame_index_reg + 14'h1) & wrap; // RULE13
    end
  end

  // frame list size, own control register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fls_reg <= hc_regs_pkg::FLS_RESET_VALUE;
    end else if (!idle) begin
      fls_reg <= hc_regs_pkg::FLS_RESET_VALUE;
    end else if (wr_ok && hit(req.addr, hc_regs_pkg::OFS_FRAME_CONTROL)) begin
      fls_reg <= req.wdata[hc_regs_pkg::FLS_W-1:0];
    end
  end

  // only controller-level events reach the status flags
  assign port_evt = |(port_status_change & ~companion_owned) ||
    |force_resume_rise; // RULE11 RULE9

  always_comb begin
    status_set = '0;
    status_set[hc_regs_pkg::STS_ROLLOVER_BIT] = rollover_evt; // RULE10
    status_set[hc_regs_pkg::STS_PORT_CHANGE_BIT] = port_evt; // RULE11
  end

  // a one clears, a zero leaves the flag alone
  assign status_clr = (wr_ok && hit(req.addr, hc_regs_pkg::OFS_HOST_STATUS)) ?
    (req.wdata & hc_regs_pkg::STS_FLAG_MASK) : 32'h0; // RULE8 RULE14

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= hc_regs_pkg::STS_RESET_VALUE;
    end else if (!idle) begin
      status_reg <= hc_regs_pkg::STS_RESET_VALUE;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set; // RULE8
    end
  end

  // reserved enable register only stores what software writes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      intr_rsvd_reg <= hc_regs_pkg::INTR_RSVD_RESET_VALUE;
    end else if (!idle) begin
      intr_rsvd_reg <= hc_regs_pkg::INTR_RSVD_RESET_VALUE;
    end else if (wr_ok &&
                 hit(req.addr, hc_regs_pkg::OFS_INTR_ENABLE_RSVD)) begin
      intr_rsvd_reg <= req.wdata; // RULE12
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= hc_regs_pkg::MASK_RESET_VALUE;
    end else if (!idle) begin
      mask_reg <= hc_regs_pkg::MASK_RESET_VALUE;
    end else if (wr_ok && hit(req.addr, hc_regs_pkg::OFS_STATUS_MASK)) begin
      mask_reg <= req.wdata & hc_regs_pkg::STS_FLAG_MASK;
    end
  end

  // registered, so the line lags the flag by one cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // read port; unmapped offsets and idle cycles return zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (!req.rd) begin
      rdata_reg <= '0;
    end else begin
      case (req.addr)
        hc_regs_pkg::OFS_HOST_COMMAND: rdata_reg <= cmd_reg; // RULE6
        hc_regs_pkg::OFS_HOST_STATUS: rdata_reg <= status_reg; // RULE8
        hc_regs_pkg::OFS_INTR_ENABLE_RSVD: rdata_reg <= intr_rsvd_reg;
        hc_regs_pkg::OFS_FRAME_CONTROL: rdata_reg <= {30'h0, fls_reg};
        hc_regs_pkg::OFS_FRAME_INDEX: rdata_reg <= {18'h0, frame_index_reg};
        hc_regs_pkg::OFS_STATUS_MASK: rdata_reg <= mask_reg;
        default: rdata_reg <= '0;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign schedule_run = cmd_reg[hc_regs_pkg::CMD_RUN_STOP_BIT]; // RULE3
  assign controller_reset = ctrl_rst_reg;
  assign port_logic_reset = port_rst_reg;
  assign frame_index = frame_index_reg;
  assign irq = irq_reg;

endmodule : usb_host_command_status_regs

// ==== verilog/hc_regs_pkg.sv ====
// register map, field layout, timing constants and carriers of the host block
package hc_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // byte offsets of the software-visible registers
  localparam logic [7:0] OFS_HOST_COMMAND = 8'h20;
  localparam logic [7:0] OFS_HOST_STATUS = 8'h24;
  localparam logic [7:0] OFS_INTR_ENABLE_RSVD = 8'h28;
  localparam logic [7:0] OFS_FRAME_CONTROL = 8'h30;
  localparam logic [7:0] OFS_FRAME_INDEX = 8'h34;
  localparam logic [7:0] OFS_STATUS_MASK = 8'h38;

  // host_command fields
  localparam int CMD_RUN_STOP_BIT = 0;
  localparam int CMD_FULL_RESET_BIT = 1;
  localparam int CMD_LIGHT_RESET_BIT = 7;
  localparam logic [31:0] CMD_RESET_VALUE = 32'h0008_0b00;

  // host_status fields
  localparam int STS_PORT_CHANGE_BIT = 2;
  localparam int STS_ROLLOVER_BIT = 3;
  localparam logic [31:0] STS_FLAG_MASK = 32'h0000_000c;
  localparam logic [31:0] STS_RESET_VALUE = 32'h0000_0000;

  localparam logic [31:0] INTR_RSVD_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET_VALUE = 32'h0000_0000;

  // frame list size select and index wrap points
  localparam int FLS_W = 2;
  localparam logic [1:0] FLS_1024 = 2'h0;
  localparam logic [1:0] FLS_512 = 2'h1;
  localparam logic [1:0] FLS_256 = 2'h2;
  localparam logic [1:0] FLS_RESET_VALUE = 2'h0;
  localparam int FRAME_INDEX_W = 14;
  localparam logic [13:0] WRAP_1024 = 14'h1fff;
  localparam logic [13:0] WRAP_512 = 14'h0fff;
  localparam logic [13:0] WRAP_256 = 14'h07ff;

  // timing
  localparam int MICROFRAME_NS = 125000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MICROFRAME_CYCLES = MICROFRAME_NS / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYCLES = 16;

  typedef enum logic [2:0] {
    CTRL_IDLE = 3'b001,
    CTRL_FULL_RESET = 3'b010,
    CTRL_LIGHT_RESET = 3'b100
  } ctrl_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : hc_regs_pkg

// ==== testbench/usb_host_cmd_props.sv ====
// port assertions for the host command and status register group
module usb_host_cmd_props #(
  parameter int NUM_PORTS = 1,
  parameter bit LIGHT_RESET_EN = 1'b1
) (
  input wire logic mclk, // core clock
  input wire logic rst_b, // reset, active low
  input wire hc_regs_pkg::reg_req_t req, // register request
  input wire logic [31:0] rdata, // read data
  input wire logic [NUM_PORTS-1:0] port_status_change, // port change
  input wire logic [NUM_PORTS-1:0] companion_owned, // owned ports
  input wire logic [NUM_PORTS-1:0] force_resume_rise, // resume seen
  input wire logic schedule_run, // run output
  input wire logic controller_reset, // reset sequence
  input wire logic port_logic_reset, // port reset
  input wire logic [13:0] frame_index, // frame index
  input wire logic irq // interrupt
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic cmd_wr;
  assign cmd_wr = req.wr && !controller_reset &&
    req.addr == hc_regs_pkg::OFS_HOST_COMMAND;

  a_rdata_idle: assert property (
    !$past(req.rd) |-> rdata == 32'h0) else $error("rdata outside slot");
  a_run_follows: assert property (
    cmd_wr && !req.wdata[1] && !req.wdata[7]
    |=> schedule_run == $past(req.wdata[0])) else $error("run wrong");
  a_full_reset_go: assert property (
    cmd_wr && req.wdata[1] |=> controller_reset && port_logic_reset &&
    !schedule_run) else $error("full reset not started");
  // without the light reset the same write must not start any sequence
  a_light_reset_go: assert property (
    cmd_wr && req.wdata[7] && !req.wdata[1]
    |=> controller_reset == LIGHT_RESET_EN && !port_logic_reset)
    else $error("light reset");
  a_reset_ends: assert property (
    $rose(controller_reset) |-> ##[1:40] !controller_reset)
    else $error("reset never ends");
  // index is cleared one edge after the sequence starts
  a_index_cleared: assert property (
    controller_reset |=> frame_index == 14'h0) else $error("index kept");
  a_index_held: assert property (
    !controller_reset && !schedule_run && !$past(schedule_run)
    |-> $stable(frame_index)) else $error("index moves while stopped");
  a_index_step: assert property (
    !controller_reset && $changed(frame_index)
    |-> frame_index == $past(frame_index) + 14'h1 || frame_index == 14'h0)
    else $error("index jump");
  c_full: cover property ($fell(controller_reset) && $past(port_logic_reset));
  c_wrap: cover property ($changed(frame_index) && frame_index == 14'h0);
  c_irq: cover property ($rose(irq));
endmodule : usb_host_cmd_props

bind usb_host_command_status_regs usb_host_cmd_props #(
  .NUM_PORTS(NUM_PORTS), .LIGHT_RESET_EN(LIGHT_RESET_EN)
) u_props (
  .mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
  .port_status_change(port_status_change),
  .companion_owned(companion_owned),
  .force_resume_rise(force_resume_rise), .schedule_run(schedule_run),
  .controller_reset(controller_reset),
  .port_logic_reset(port_logic_reset), .frame_index(frame_index), .irq(irq)
);

// ==== testbench/tb_usb_host_command_status_regs.sv ====
// self-checking bench for the host command and status register group
module tb_usb_host_command_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic rst_b;
  hc_regs_pkg::reg_req_t req;
  logic [31:0] rdata;
  logic [1:0] chg;
  logic [1:0] owned;
  logic [1:0] resume;
  logic run;
  logic crst;
  logic prst;
  logic [13:0] fidx;
  logic irq;
  logic [13:0] held;
  logic [31:0] rdata_nl;
  logic crst_nl;
  int bad_count;
  int tests_run;

  // short counts keep the rollover walk near 8k cycles
  usb_host_command_status_regs #(
    .NUM_PORTS(2), .MICROFRAME_CYCLES(4), .RESET_HOLD_CYCLES(2),
    .LIGHT_RESET_EN(1'b1)
  ) dut (
    .mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .port_status_change(chg), .companion_owned(owned),
    .force_resume_rise(resume), .schedule_run(run),
    .controller_reset(crst), .port_logic_reset(prst),
    .frame_index(fidx), .irq(irq)
  );

  // same traffic, light reset left out, to see bit 7 forced low
  usb_host_command_status_regs #(
    .NUM_PORTS(2), .MICROFRAME_CYCLES(4), .RESET_HOLD_CYCLES(2),
    .LIGHT_RESET_EN(1'b0)
  ) dut_nl (
    .mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata_nl),
    .port_status_change(chg), .companion_owned(owned),
    .force_resume_rise(resume), .schedule_run(),
    .controller_reset(crst_nl), .port_logic_reset(),
    .frame_index(), .irq()
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd

  task automatic pulse(input logic [1:0] c, input logic [1:0] f);
    @(posedge mclk);
    chg <= c;
    resume <= f;
    @(posedge mclk);
    chg <= 2'h0;
    resume <= 2'h0;
  endtask : pulse

  // waits on the index value, or on the reset sequence to end
  task automatic wait_for(input bit on_idx, input logic [13:0] v);
    int n;
    n = 0;
    while ((on_idx ? fidx !== v : crst !== 1'b0) && n < 9000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 9000) begin
      bad_count++;
      $display("BAD %0t wait ran out", $time);
      give_verdict();
    end
  endtask : wait_for

  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_b = 1'b0;
    req = '0;
    chg = 2'h0;
    owned = 2'h1;
    resume = 2'h0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    rd(8'h20, 32'h0008_0b00);
    rd(8'h24, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h28, 32'ha5a5_5a5a);
    rd(8'h28, 32'ha5a5_5a5a);
    pulse(2'h1, 2'h0);
    rd(8'h24, 32'h0);
    pulse(2'h2, 2'h0);
    rd(8'h24, 32'h4);
    wr(8'h24, 32'h0);
    rd(8'h24, 32'h4);
    wr(8'h38, 32'h4);
    rd(8'h38, 32'h4);
    check({31'h0, irq}, 32'h1);
    wr(8'h24, 32'h4);
    rd(8'h24, 32'h0);
    check({31'h0, irq}, 32'h0);
    pulse(2'h0, 2'h1);
    rd(8'h24, 32'h4);
    wr(8'h24, 32'h4);
    wr(8'h30, 32'h2);
    wr(8'h38, 32'h8);
    wr(8'h20, 32'h0008_0b01);
    check({31'h0, run}, 32'h1);
    wait_for(1'b1, 14'h7ff);
    wait_for(1'b1, 14'h0);
    rd(8'h24, 32'h8);
    check({31'h0, irq}, 32'h1);
    wr(8'h20, 32'h0008_0b00);
    held = fidx;
    repeat (12) @(posedge mclk);
    check({18'h0, fidx}, {18'h0, held});
    wr(8'h20, 32'h0008_0b03);
    check({30'h0, crst, prst}, 32'h3);
    wait_for(1'b0, 14'h0);
    rd(8'h20, 32'h0008_0b00);
    rd(8'h24, 32'h0);
    rd(8'h28, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(8'h20, 32'h0008_0b80);
    check({30'h0, crst, prst}, 32'h2);
    check({31'h0, crst_nl}, 32'h0);
    rd(8'h20, 32'h0008_0b80);
    check(rdata_nl, 32'h0008_0b00);
    wait_for(1'b0, 14'h0);
    rd(8'h20, 32'h0008_0b00);
    give_verdict();
  end
endmodule : tb_usb_host_command_status_regs
